// >>> hdl/irlc_top.v
// What this block does
// - Bit 31 reads line pending state
// - Pending also mirrored in controller pending words
// - Bit 30 one sets software request
// - Bit 29 one clears software request
// - Priority, polarity change only with gate bits
// - Enable changes only with bit 26
// - Bits 24 to 18 read zero
// - Every line has its own request register
// - General bus request ORs six error events
// - Message received ORs receive and identifier
// - Bit 17 selects active-low request polarity
// - Bit 16 enables line, reset off
// - Bit 8 routes normal, zero routes fast
// - Bits 3 to 0 priority, zero masks
//
// Register access over APB and the register addresses were decided locally.
`timescale 1ns/1ps
`include "irlc_map.vh"

module irlc_top (
    input wire i_mclk,
    input wire i_srst,
    input wire i_psel,
    input wire i_penable,
    input wire i_pwrite,
    input wire [`IRLC_AW-1:0] i_paddr,
    input wire [`IRLC_DW-1:0] i_pwdata,
    output reg [`IRLC_DW-1:0] o_prdata,
    output wire o_pready,
    output wire o_pslverr,
    input wire [`IRLC_NLINES-1:0] i_line_req,
    input wire [`IRLC_NCAN-1:0] i_error_warning_event,
    input wire [`IRLC_NCAN-1:0] i_data_overrun_event,
    input wire [`IRLC_NCAN-1:0] i_error_passive_event,
    input wire [`IRLC_NCAN-1:0] i_arbitration_lost_event,
    input wire [`IRLC_NCAN-1:0] i_bus_error_event,
    input wire i_lookup_table_error_event,
    input wire [`IRLC_NCAN-1:0] i_receive_event,
    input wire [`IRLC_NCAN-1:0] i_identifier_ready_event,
    output reg [`IRLC_NLINES-1:0] o_normal_req_lines,
    output reg [`IRLC_NLINES-1:0] o_fast_req_lines,
    output reg [`IRLC_NLINES*`IRLC_PRIO_W-1:0] o_line_priority,
    output reg o_normal_cpu_interrupt,
    output reg o_fast_cpu_interrupt
);

    // ======================================================================
    // Declarations
    // ======================================================================
    wire can_general_req;
    wire [`IRLC_NCAN-1:0] can_msg_rx_req;
    reg [`IRLC_NLINES-1:0] hw_req;
    wire [`IRLC_NLINES*`IRLC_DW-1:0] line_rdata;
    wire [`IRLC_NLINES-1:0] line_pending;
    wire [`IRLC_NLINES-1:0] line_enable;
    wire [`IRLC_NLINES-1:0] line_target;
    wire [`IRLC_NLINES*`IRLC_PRIO_W-1:0] line_prio;
    wire [`IRLC_NLINES-1:0] line_live;
    wire [`IRLC_NLINES-1:0] normal_next;
    wire [`IRLC_NLINES-1:0] fast_next;
    wire [`IRLC_PEND_W-1:0] pend_vec;
    wire [`IRLC_AW-1:0] req_offset;
    wire [`IRLC_IDX_W-1:0] line_idx;
    wire hit_line;
    wire hit_pend_lo;
    wire hit_pend_hi;
    wire hit_any;
    wire setup_phase;
    wire access_phase;
    wire [`IRLC_NLINES-1:0] line_wr;
    reg [`IRLC_DW-1:0] prdata_next;
    reg unmapped_reg;

    // ======================================================================
    // Source combining
    // ======================================================================
    // The bus controllers share lines, so their events are merged first
    irlc_can_comb u_can_comb (
        .i_error_warning_event(i_error_warning_event),
        .i_data_overrun_event(i_data_overrun_event),
        .i_error_passive_event(i_error_passive_event),
        .i_arbitration_lost_event(i_arbitration_lost_event),
        .i_bus_error_event(i_bus_error_event),
        .i_lookup_table_error_event(i_lookup_table_error_event),
        .i_receive_event(i_receive_event),
        .i_identifier_ready_event(i_identifier_ready_event),
        .o_general_req(can_general_req),
        .o_msg_rx_req(can_msg_rx_req)
    );

    // Merged requests are ORed onto their lines so a direct input there still works
    always @* begin
        hw_req = i_line_req;
        hw_req[`IRLC_CAN_GEN_IDX] = i_line_req[`IRLC_CAN_GEN_IDX] | can_general_req;
        hw_req[`IRLC_CAN0_RX_IDX] = i_line_req[`IRLC_CAN0_RX_IDX] | can_msg_rx_req[0];
        hw_req[`IRLC_CAN1_RX_IDX] = i_line_req[`IRLC_CAN1_RX_IDX] | can_msg_rx_req[1];
    end

    // ======================================================================
    // Address decode
    // ======================================================================
    // Line n sits one word above line n-1, starting at the base for line 1
    assign req_offset = i_paddr - `IRLC_REQ_BASE;
    assign line_idx = req_offset[`IRLC_IDX_W+1:2];
    assign hit_line = (i_paddr >= `IRLC_REQ_BASE) && (i_paddr <= `IRLC_REQ_LAST) &&
                      (i_paddr[1:0] == 2'h0);
    assign hit_pend_lo = (i_paddr == `IRLC_PEND_LO);
    assign hit_pend_hi = (i_paddr == `IRLC_PEND_HI);
    assign hit_any = hit_line | hit_pend_lo | hit_pend_hi;

    assign setup_phase = i_psel & ~i_penable;
    assign access_phase = i_psel & i_penable;

    // ======================================================================
    // Per-line request registers
    // ======================================================================
    genvar g;
    generate
        for (g = 0; g < `IRLC_NLINES; g = g + 1) begin : g_line
            // Line number at the width of the decoded index, so the compare is exact
            localparam [`IRLC_IDX_W-1:0] LINE_NUM = g;

            // Write strobe fires only on the completing access edge
            assign line_wr[g] = access_phase & i_pwrite & hit_line &
                                (line_idx == LINE_NUM);

            irlc_line u_line (
                .i_mclk(i_mclk),
                .i_srst(i_srst),
                .i_wr(line_wr[g]),
                .i_wdata(i_pwdata),
                .i_hw_req(hw_req[g]),
                .o_rdata(line_rdata[g*`IRLC_DW +: `IRLC_DW]),
                .o_pending(line_pending[g]),
                .o_enable(line_enable[g]),
                .o_target(line_target[g]),
                .o_priority(line_prio[g*`IRLC_PRIO_W +: `IRLC_PRIO_W])
            );

            // A line reaches the core only if enabled and not masked by priority
            assign line_live[g] = line_pending[g] & line_enable[g] &
                                  (line_prio[g*`IRLC_PRIO_W +: `IRLC_PRIO_W] !=
                                   `IRLC_PRIO_MASKED);
            assign normal_next[g] = line_live[g] &
                                    (line_target[g] == `IRLC_TGT_NORMAL);
            assign fast_next[g] = line_live[g] &
                                  (line_target[g] != `IRLC_TGT_NORMAL);
        end
    endgenerate

    // ======================================================================
    // Controller-wide pending view
    // ======================================================================
    // Bit n of the pending words is line n; bit 0 and bits above 56 are unused
    assign pend_vec = {7'h00, line_pending, 1'h0};

    // ======================================================================
    // Register bus slave
    // ======================================================================
    // Zero wait states: read data is captured in the setup cycle
    assign o_pready = 1'h1;
    // Unmapped accesses end with an error; writes to pending words are ignored
    assign o_pslverr = access_phase & unmapped_reg;

    // Read mux; the pending words share the same line_pending vector as bit 31
    always @* begin
        prdata_next = {`IRLC_DW{1'h0}};
        if (hit_line) begin
            prdata_next = line_rdata[{line_idx, 5'h00} +: `IRLC_DW];
        end else if (hit_pend_lo) begin
            prdata_next = pend_vec[`IRLC_DW-1:0];
        end else if (hit_pend_hi) begin
            prdata_next = pend_vec[`IRLC_PEND_W-1:`IRLC_DW];
        end
    end

    // Capture read data and decode result once per transfer
    always @(posedge i_mclk) begin
        if (i_srst) begin
            o_prdata <= {`IRLC_DW{1'h0}};
            unmapped_reg <= 1'h0;
        end else if (setup_phase) begin
            o_prdata <= i_pwrite ? {`IRLC_DW{1'h0}} : prdata_next;
            unmapped_reg <= ~hit_any;
        end
    end

    // ======================================================================
    // Outputs to the core and the arbiter
    // ======================================================================
    // Registered so the core sees glitch-free levels; costs one cycle latency
    always @(posedge i_mclk) begin
        if (i_srst) begin
            o_normal_req_lines <= {`IRLC_NLINES{1'h0}};
            o_fast_req_lines <= {`IRLC_NLINES{1'h0}};
            o_line_priority <= {`IRLC_NLINES*`IRLC_PRIO_W{1'h0}};
            o_normal_cpu_interrupt <= 1'h0;
            o_fast_cpu_interrupt <= 1'h0;
        end else begin
            o_normal_req_lines <= normal_next;
            o_fast_req_lines <= fast_next;
            o_line_priority <= line_prio;
            o_normal_cpu_interrupt <= |normal_next;
            o_fast_cpu_interrupt <= |fast_next;
        end
    end

    // Retargeting a live line moves its request to the other output on one edge, never onto both;
    // software is expected to disable the line around the change.

endmodule

// >>> include/irlc_map.vh
`ifndef IRLC_MAP_VH
`define IRLC_MAP_VH

// ==========================================================================
// Geometry
// ==========================================================================
`define IRLC_NLINES 56
`define IRLC_IDX_W 6
`define IRLC_AW 12
`define IRLC_DW 32
`define IRLC_PEND_W 64

// ==========================================================================
// Register map (byte addresses on the register bus)
// ==========================================================================
`define IRLC_REQ_BASE 12'h404
`define IRLC_REQ_LAST 12'h4E0
`define IRLC_PEND_LO 12'h200
`define IRLC_PEND_HI 12'h204

// ==========================================================================
// Line request register fields
// ==========================================================================
`define IRLC_PENDING_BIT 31
`define IRLC_SET_SW_BIT 30
`define IRLC_CLR_SW_BIT 29
`define IRLC_WE_PRIO_BIT 28
`define IRLC_WE_TGT_BIT 27
`define IRLC_WE_EN_BIT 26
`define IRLC_WE_POL_BIT 25
`define IRLC_POL_BIT 17
`define IRLC_EN_BIT 16
`define IRLC_TGT_BIT 8
`define IRLC_PRIO_MSB 3
`define IRLC_PRIO_LSB 0
`define IRLC_PRIO_W 4

// ==========================================================================
// Reset values and field encodings
// ==========================================================================
`define IRLC_POL_RST 1'h0
`define IRLC_EN_RST 1'h0
`define IRLC_TGT_RST 1'h0
`define IRLC_PRIO_RST 4'h0
`define IRLC_SW_RST 1'h0
`define IRLC_PRIO_MASKED 4'h0
`define IRLC_TGT_NORMAL 1'h1

// ==========================================================================
// Line indices of the combined bus controller requests (line n at index n-1)
// ==========================================================================
`define IRLC_CAN_GEN_IDX 35
`define IRLC_CAN0_RX_IDX 36
`define IRLC_CAN1_RX_IDX 37
`define IRLC_NCAN 2

`endif

// >>> hdl/irlc_can_comb.v
`timescale 1ns/1ps
`include "irlc_map.vh"

// ==========================================================================
// Bus controller request combiner
// ==========================================================================
module irlc_can_comb (
    input wire [`IRLC_NCAN-1:0] i_error_warning_event,
    input wire [`IRLC_NCAN-1:0] i_data_overrun_event,
    input wire [`IRLC_NCAN-1:0] i_error_passive_event,
    input wire [`IRLC_NCAN-1:0] i_arbitration_lost_event,
    input wire [`IRLC_NCAN-1:0] i_bus_error_event,
    input wire i_lookup_table_error_event,
    input wire [`IRLC_NCAN-1:0] i_receive_event,
    input wire [`IRLC_NCAN-1:0] i_identifier_ready_event,
    output wire o_general_req,
    output wire [`IRLC_NCAN-1:0] o_msg_rx_req
);

    // All error kinds of every controller share one line
    assign o_general_req = (|i_error_warning_event) | (|i_data_overrun_event) |
                           (|i_error_passive_event) | (|i_arbitration_lost_event) |
                           (|i_bus_error_event) | i_lookup_table_error_event;

    // Each controller has its own message-received line
    assign o_msg_rx_req = i_receive_event | i_identifier_ready_event;

endmodule

// >>> hdl/irlc_line.v
`timescale 1ns/1ps
`include "irlc_map.vh"

// ==========================================================================
// One interrupt line: configuration and software request latch
// ==========================================================================
module irlc_line (
    input wire i_mclk,
    input wire i_srst,
    input wire i_wr,
    input wire [`IRLC_DW-1:0] i_wdata,
    input wire i_hw_req,
    output wire [`IRLC_DW-1:0] o_rdata,
    output wire o_pending,
    output wire o_enable,
    output wire o_target,
    output wire [`IRLC_PRIO_W-1:0] o_priority
);

    reg pol_reg;
    reg en_reg;
    reg tgt_reg;
    reg [`IRLC_PRIO_W-1:0] prio_reg;
    reg sw_reg;

    // Each field moves only when its gate bit is set in the same write
    always @(posedge i_mclk) begin
        if (i_srst) begin
            pol_reg <= `IRLC_POL_RST;
            en_reg <= `IRLC_EN_RST;
            tgt_reg <= `IRLC_TGT_RST;
            prio_reg <= `IRLC_PRIO_RST;
        end else if (i_wr) begin
            if (i_wdata[`IRLC_WE_PRIO_BIT]) begin
                prio_reg <= i_wdata[`IRLC_PRIO_MSB:`IRLC_PRIO_LSB];
            end
            if (i_wdata[`IRLC_WE_POL_BIT]) begin
                pol_reg <= i_wdata[`IRLC_POL_BIT];
            end
            if (i_wdata[`IRLC_WE_EN_BIT]) begin
                en_reg <= i_wdata[`IRLC_EN_BIT];
            end
            if (i_wdata[`IRLC_WE_TGT_BIT]) begin
                tgt_reg <= i_wdata[`IRLC_TGT_BIT];
            end
        end
    end

    // Software request latch; set beats clear when both are written at once
    always @(posedge i_mclk) begin
        if (i_srst) begin
            sw_reg <= `IRLC_SW_RST;
        end else if (i_wr && i_wdata[`IRLC_SET_SW_BIT]) begin
            sw_reg <= 1'h1;
        end else if (i_wr && i_wdata[`IRLC_CLR_SW_BIT]) begin
            sw_reg <= 1'h0;
        end
    end

    // Polarity-corrected hardware request merged with the software request
    assign o_pending = (i_hw_req ^ pol_reg) | sw_reg;
    assign o_enable = en_reg;
    assign o_target = tgt_reg;
    assign o_priority = prio_reg;

    // Strobes, gates and reserved bits all read back as zero
    assign o_rdata = {o_pending, 6'h00, 7'h00, pol_reg, en_reg, 7'h00, tgt_reg,
                      4'h0, prio_reg};

endmodule

// >>> dv/irlc_src_model.sv
`timescale 1ns/1ps
`include "irlc_map.vh"

// ==========================================================================
// Peripheral request sources and bus controller event lines
// ==========================================================================
module irlc_src_model (
    input wire i_mclk,
    input wire [`IRLC_NLINES-1:0] i_req_cmd,
    input wire [14:0] i_can_cmd,
    output reg [`IRLC_NLINES-1:0] o_line_req,
    output reg [14:0] o_can_ev
);
    // Sources are flops of their own, so levels move just after an edge and stand
    always @(posedge i_mclk) begin
        o_line_req <= i_req_cmd;
        o_can_ev <= i_can_cmd;
    end
endmodule

// >>> dv/irlc_top_assertions.sv
`timescale 1ns/1ps
`include "irlc_map.vh"

// ==========================================================================
// Bus answer and request routing checks
// ==========================================================================
module irlc_chk (
    input wire i_mclk,
    input wire i_srst,
    input wire i_psel,
    input wire i_penable,
    input wire i_pwrite,
    input wire [`IRLC_AW-1:0] i_paddr,
    input wire [`IRLC_DW-1:0] o_prdata,
    input wire o_pready,
    input wire o_pslverr,
    input wire [`IRLC_NLINES-1:0] o_normal_req_lines,
    input wire [`IRLC_NLINES-1:0] o_fast_req_lines,
    input wire [`IRLC_NLINES*`IRLC_PRIO_W-1:0] o_line_priority
);
    default clocking @(posedge i_mclk); endclocking
    default disable iff (i_srst);
    // Aligned words only; an odd offset inside the range is not a register
    wire is_line = i_paddr >= `IRLC_REQ_BASE && i_paddr <= `IRLC_REQ_LAST
        && i_paddr[1:0] == 2'h0;
    wire is_map = is_line || i_paddr == `IRLC_PEND_LO || i_paddr == `IRLC_PEND_HI;
    // Setup then access phase of a line register read or of a stray access
    sequence s_line_rd;
        i_psel && !i_penable && !i_pwrite && is_line ##1 i_psel && i_penable;
    endsequence
    sequence s_bad;
        i_psel && !i_penable && !is_map ##1 i_psel && i_penable;
    endsequence
    a_set_reads_zero: assert property (s_line_rd |-> !o_prdata[30])
        else $error("set strobe read back high");
    a_clr_reads_zero: assert property (s_line_rd |-> !o_prdata[29])
        else $error("clear strobe read back high");
    a_gates_read_zero: assert property (s_line_rd |-> !o_prdata[28] && !o_prdata[25])
        else $error("priority or polarity gate read back high");
    a_en_gate_zero: assert property (s_line_rd |-> !o_prdata[26])
        else $error("enable gate read back high");
    a_tgt_gate_zero: assert property (s_line_rd |-> !o_prdata[27])
        else $error("target gate read back high");
    a_reserved_read_zero: assert property (s_line_rd |-> o_prdata[24:18] == 7'h00)
        else $error("reserved bits read nonzero");
    a_unmapped_err: assert property (s_bad |-> o_pslverr)
        else $error("stray access not flagged");
    a_ready_const: assert property (o_pready)
        else $error("ready dropped");
    a_route_exclusive: assert property (!(|(o_normal_req_lines & o_fast_req_lines)))
        else $error("line routed to both inputs");
    a_masked_silent: assert property ((o_line_priority[3:0] == 4'h0)
        |-> !o_normal_req_lines[0] && !o_fast_req_lines[0])
        else $error("masked line still requests");
endmodule

bind irlc_top irlc_chk u_chk (
    .i_mclk(i_mclk),
    .i_srst(i_srst),
    .i_psel(i_psel),
    .i_penable(i_penable),
    .i_pwrite(i_pwrite),
    .i_paddr(i_paddr),
    .o_prdata(o_prdata),
    .o_pready(o_pready),
    .o_pslverr(o_pslverr),
    .o_normal_req_lines(o_normal_req_lines),
    .o_fast_req_lines(o_fast_req_lines),
    .o_line_priority(o_line_priority)
);

// >>> dv/irlc_top_tb.sv
`timescale 1ns/1ps
`include "irlc_map.vh"

// ==========================================================================
// Register bus bench for the line request block
// ==========================================================================
module irlc_top_tb;
    logic i_mclk = 0;
    logic i_srst = 1;
    logic psel = 0;
    logic penable = 0;
    logic pwrite = 0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic [31:0] rv;
    logic pready, pslverr, nint, fint, ev, rdy;
    logic [55:0] req_cmd = 56'h0;
    logic [55:0] line_req, nlines, flines;
    logic [14:0] can_cmd = 15'h0;
    logic [14:0] can_ev;
    logic [223:0] prio;
    int mismatches = 0;
    int checks_done = 0;

    // ======================================================================
    // Clock, sources and design
    // ======================================================================
    initial forever #2.5 i_mclk = ~i_mclk;
    irlc_src_model u_src (.i_mclk(i_mclk), .i_req_cmd(req_cmd), .i_can_cmd(can_cmd),
        .o_line_req(line_req), .o_can_ev(can_ev));
    irlc_top DUT (.i_mclk(i_mclk), .i_srst(i_srst), .i_psel(psel), .i_penable(penable),
        .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
        .o_pready(pready), .o_pslverr(pslverr), .i_line_req(line_req),
        .i_error_warning_event(can_ev[1:0]), .i_data_overrun_event(can_ev[3:2]),
        .i_error_passive_event(can_ev[5:4]), .i_arbitration_lost_event(can_ev[7:6]),
        .i_bus_error_event(can_ev[9:8]), .i_lookup_table_error_event(can_ev[10]),
        .i_receive_event(can_ev[12:11]), .i_identifier_ready_event(can_ev[14:13]),
        .o_normal_req_lines(nlines), .o_fast_req_lines(flines), .o_line_priority(prio),
        .o_normal_cpu_interrupt(nint), .o_fast_cpu_interrupt(fint));

    // ======================================================================
    // Tasks
    // ======================================================================
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected %s: expected %h seen %h", nm, exp, seen);
        end
    endtask
    // Answer is taken at the closing edge, before that edge's own updates land
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge i_mclk);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge i_mclk);
        penable <= 1;
        do begin
            @(posedge i_mclk);
            rv = prdata;
            ev = pslverr;
            rdy = pready;
            n++;
        end while (rdy !== 1'b1 && n < 20);
        psel <= 0;
        penable <= 0;
        chk("pready", 32'(rdy), 32'h1);
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] exp, input string nm);
        apb(1'b0, a, 32'h0);
        chk(nm, rv, exp);
    endtask
    // Source flop plus the registered outputs, with margin
    task automatic settle;
        repeat (3) @(posedge i_mclk);
        @(negedge i_mclk);
    endtask
    function automatic logic [11:0] la(input int n);
        return `IRLC_REQ_BASE + 12'(4 * (n - 1));
    endfunction
    task automatic conclude;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // ======================================================================
    // Tests
    // ======================================================================
    initial begin
        repeat (3) @(posedge i_mclk);
        i_srst <= 0;
        rd(la(1), 32'h0, "line1_rst");
        rd(`IRLC_PEND_LO, 32'h0, "pend_rst");
        apb(1'b0, 12'h300, 32'h0);
        chk("slverr", 32'(ev), 32'h1);
        // Gated write, then a gateless one that tries the polarity bit and reserved bits 24 to 18
        wr(la(1), 32'h1C01010F);
        rd(la(1), 32'h0001010F, "gated");
        wr(la(1), 32'h01FE0000);
        rd(la(1), 32'h0001010F, "ungated");
        rd(la(2), 32'h0, "line2");
        req_cmd <= 56'h1;
        settle;
        rd(la(1), 32'h8001010F, "hw_pend");
        chk("prio_out", 32'(prio[3:0]), 32'hF);
        rd(`IRLC_PEND_LO, 32'h2, "pend_hw");
        chk("normal", 32'({nint, nlines[0], flines[0]}), 32'h6);
        // Polarity flip turns a held high request off, a low one on
        wr(la(1), 32'h02020000);
        rd(la(1), 32'h0003010F, "act_low");
        chk("no_int", 32'(nint), 32'h0);
        req_cmd <= 56'h0;
        settle;
        rd(la(1), 32'h8003010F, "low_pend");
        // Retarget only while disabled
        wr(la(1), 32'h04000000);
        settle;
        chk("disabled", 32'({nint, fint}), 32'h0);
        wr(la(1), 32'h08000000);
        wr(la(1), 32'h04010000);
        settle;
        chk("fast", 32'({fint, flines[0], nlines[0]}), 32'h6);
        wr(la(1), 32'h10000000);
        settle;
        chk("masked", 32'({fint, flines[0]}), 32'h0);
        chk("prio_zero", 32'(prio[3:0]), 32'h0);
        rd(la(1), 32'h80030000, "mask_pend");
        // Software request latch; set wins over clear in one write
        wr(la(2), 32'h40000000);
        rd(la(2), 32'h80000000, "sw_set");
        rd(`IRLC_PEND_LO, 32'h6, "pend_sw");
        wr(la(2), 32'h0);
        rd(la(2), 32'h80000000, "sw_hold");
        wr(la(2), 32'h20000000);
        rd(la(2), 32'h0, "sw_clr");
        wr(la(2), 32'h60000000);
        rd(la(2), 32'h80000000, "set_wins");
        wr(la(2), 32'h20000000);
        // Each bus controller event alone, onto the merged lines
        for (int n = 36; n <= 38; n++) wr(la(n), 32'h1C01010F);
        for (int b = 0; b < 15; b++) begin
            can_cmd <= 15'(1 << b);
            settle;
            chk("can", 32'(nlines[37:35]), b < 11 ? 32'h1 : (b % 2 ? 32'h2 : 32'h4));
        end
        rd(`IRLC_PEND_HI, 32'h40, "pend_hi");
        conclude;
    end

    // A hang ends through the same verdict
    initial begin
        repeat (5000) @(posedge i_mclk);
        mismatches++;
        conclude;
    end
endmodule
